// *** rtl/wmhs_pkg.sv ***
// Shared constants and types for the host link and power control block
package wmhs_pkg;
	localparam int unsigned CLK_HZ          = 25_000_000;
	localparam int unsigned MS_PER_S        = 1000;
	localparam int unsigned STARTUP_MS      = 300;
	localparam int unsigned DOZE_EXIT_MS    = 200;
	localparam int unsigned STARTUP_CYC     = CLK_HZ / MS_PER_S * STARTUP_MS;
	localparam int unsigned DOZE_EXIT_CYC   = CLK_HZ / MS_PER_S * DOZE_EXIT_MS;
	localparam int unsigned SPI_MAX_SCK_HZ  = 25_000_000;
	localparam int unsigned SPI_BYTE_BITS   = 8;
	localparam int unsigned TRACE_BAUD      = 19200;
	localparam int unsigned TRACE_BIT_CYC   = CLK_HZ / TRACE_BAUD;
	localparam int unsigned TRACE_DATA_BITS = 8;
	localparam int unsigned TRACE_STOP_BITS = 1;
	localparam logic [7:0]  TRACE_CODE_BASE = 8'h30;

	typedef enum logic [2:0] {
		PWR_HELD    = 3'h0,
		PWR_START   = 3'h1,
		PWR_STANDBY = 3'h2,
		PWR_RX      = 3'h3,
		PWR_TX      = 3'h4,
		PWR_DOZE    = 3'h5,
		PWR_DTIM    = 3'h6,
		PWR_WAKE    = 3'h7
	} wmhs_pwr_t;
endpackage

// *** rtl/wmhs_top.sv ***
// Host SPI slave, data-available interrupt, power states and trace port
// Notes on behaviour
// - Power-down pin high turns core regulators off
// - Bad supply holds the module in reset
// - Start-up completes about 300 ms after reset
// - Power-down keeps no internal state; here hostByte and the SPI link-domain registers keep their values
// - Doze entered when enabled and all idle
// - Doze wakes each DTIM, fetches queued traffic
// - Leaving doze for transfer takes 200 ms
// - Stand-by is internal only, never host-selected
// - Trace port is 19200 baud, 8N1
// - Interrupt low while data waits
// - Interrupt released once data reaches host
// - Serial clock up to 25 MHz
// - Both clock modes 0 and 3 work
// - Sampling starts at first rising edge
// - Bytes shift most significant bit first
// - Select fall starts, rise ends a transfer
// - Interrupt is open drain, drives only low
`timescale 1ns/1ps
module wmhs_top import wmhs_pkg::*; #(
	parameter int unsigned STARTUP_CYCLES = STARTUP_CYC,
	parameter int unsigned WAKE_CYCLES    = DOZE_EXIT_CYC,
	parameter int unsigned TRACE_CYCLES   = TRACE_BIT_CYC
) (
	// Clock, reset, enable
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        clkEn,
	// Power and reset pins
	input  wire logic        hibernatePin,
	input  wire logic        resetPinN,
	input  wire logic        supplyOk,
	// SPI link
	input  wire logic        spiSck,
	input  wire logic        spiCsN,
	input  wire logic        spiSdi,
	output logic             spiSdo,
	// Data-available interrupt, open drain
	output logic             intPinO,
	output logic             intPinOe,
	// Trace port
	output logic             traceSerialOut,
	// Core side, data toward host
	input  wire logic [7:0]  coreDataByte,
	input  wire logic        coreDataValid,
	output logic             coreDataReady,
	// Core side, bytes from host
	output logic [7:0]       hostByte,
	output logic             hostByteValid,
	// Core side, power management
	input  wire logic        dozeEnable,
	input  wire logic        activityBusy,
	input  wire logic        dtimTick,
	input  wire logic        trafficQueued,
	input  wire logic        rxActive,
	input  wire logic        txRequest,
	// Status
	output logic             regulatorsOn,
	output logic             coreResetN,
	output logic             startupDone,
	output logic [2:0]       powerState
);
	localparam int unsigned TMAX = (STARTUP_CYCLES > WAKE_CYCLES) ?
		STARTUP_CYCLES : WAKE_CYCLES;
	localparam int unsigned TW   = $clog2(TMAX + 1);
	localparam int unsigned BW   = $clog2(SPI_BYTE_BITS);

	// Pin synchronisers, sys domain
	logic [1:0] hibSync_q;
	logic [1:0] rstPinSync_q;
	logic [1:0] supSync_q;
	logic [1:0] csSync_q;
	logic [1:0] togSync_q;
	logic       hibS;
	logic       rstPinNS;
	logic       supS;
	logic       csS;
	// Link domain has no reset; a known start keeps the toggle edge clean
	logic       rxTog = 1'b0;
	logic       startupDone_q;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			hibSync_q    <= 2'h3;
			rstPinSync_q <= 2'h0;
			supSync_q    <= 2'h0;
			csSync_q     <= 2'h3;
			togSync_q    <= 2'h0;
		end else if (clkEn) begin
			hibSync_q    <= {hibSync_q[0], hibernatePin};
			rstPinSync_q <= {rstPinSync_q[0], resetPinN};
			supSync_q    <= {supSync_q[0], supplyOk};
			csSync_q     <= {csSync_q[0], spiCsN};
			togSync_q    <= {togSync_q[0], rxTog};
		end
	end

	assign hibS     = hibSync_q[1];
	assign rstPinNS = rstPinSync_q[1];
	assign supS     = supSync_q[1];
	assign csS      = csSync_q[1];

	logic holdReset;
	assign holdReset = hibS || !supS || !rstPinNS;

	// SPI shifter, link domain; select high clears the frame
	logic [BW-1:0] bitCnt;
	logic [6:0]    shiftIn;
	logic [7:0]    rxByteSck;
	logic          sdoQ;
	logic [7:0]    pend_q;

	// Clocked straight by the host clock, so full link rate is kept
	always_ff @(posedge spiSck or posedge spiCsN) begin
		if (spiCsN) begin
			bitCnt  <= '0;
			shiftIn <= '0;
		end else begin
			shiftIn <= {shiftIn[5:0], spiSdi};
			bitCnt  <= bitCnt + 1'b1;
		end
	end

	// Byte word stays put for eight edges, long enough for the toggle
	always_ff @(posedge spiSck) begin
		if (!spiCsN && bitCnt == BW'(SPI_BYTE_BITS - 1)) begin
			rxByteSck <= {shiftIn, spiSdi};
			rxTog     <= ~rxTog;
		end
	end

	// Launch on falling edge gives a full half period of hold
	always_ff @(negedge spiSck or posedge spiCsN) begin
		if (spiCsN) begin
			sdoQ <= 1'b0;
		end else begin
			sdoQ <= pend_q[~bitCnt];
		end
	end

	// MSB must be out before the first rising edge in mode 0
	assign spiSdo = (bitCnt == '0) ? pend_q[SPI_BYTE_BITS-1] : sdoQ;

	// Frame tracking and received bytes, sys domain
	logic       csPrev_q;
	logic       togPrev_q;
	logic       csRise;
	logic       rxEv;
	logic       byteSeen_q;
	logic [7:0] hostByte_q;
	logic       hostValid_q;

	assign csRise = csS && !csPrev_q;
	assign rxEv   = togSync_q[1] ^ togPrev_q;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			csPrev_q    <= 1'b1;
			togPrev_q   <= 1'b0;
			hostByte_q  <= 8'h00;
			hostValid_q <= 1'b0;
		end else if (clkEn) begin
			csPrev_q    <= csS;
			togPrev_q   <= togSync_q[1];
			hostValid_q <= rxEv;
			if (rxEv) begin
				hostByte_q <= rxByteSck;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst || hibS) begin
			byteSeen_q <= 1'b0;
		end else if (clkEn) begin
			if (csRise) begin
				byteSeen_q <= 1'b0;
			end else if (rxEv) begin
				byteSeen_q <= 1'b1;
			end
		end
	end

	// Data waiting for the host; loads only between frames
	logic pending_q;
	logic loadData;
	logic xferDone;
	logic dataRdy_q;

	assign loadData = coreDataValid && dataRdy_q;
	assign xferDone = csRise && (byteSeen_q || rxEv);

	always_ff @(posedge sys_clk) begin
		if (rst || hibS) begin
			pending_q <= 1'b0;
			pend_q    <= 8'h00;
			dataRdy_q <= 1'b0;
		end else if (clkEn) begin
			if (loadData) begin
				pending_q <= 1'b1;
				pend_q    <= coreDataByte;
			end else if (xferDone) begin
				pending_q <= 1'b0;
			end
			dataRdy_q <= !pending_q && !loadData && csS && startupDone_q;
		end
	end

	// Open drain: only the enable moves, the level is always low
	logic intOe_q;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			intOe_q <= 1'b0;
		end else if (clkEn) begin
			intOe_q <= pending_q && !hibS;
		end
	end

	// Power state machine
	wmhs_pwr_t       state_q;
	wmhs_pwr_t       stateD;
	logic [TW-1:0]   timer_q;
	logic            idleNow;

	assign idleNow = !activityBusy && !pending_q && !txRequest && !rxActive;

	always_comb begin
		stateD = state_q;
		case (state_q)
			PWR_HELD: begin
				stateD = PWR_START;
			end
			PWR_START: begin
				if (timer_q == '0) begin
					stateD = PWR_STANDBY;
				end
			end
			PWR_STANDBY: begin
				if (txRequest) begin
					stateD = PWR_TX;
				end else if (rxActive) begin
					stateD = PWR_RX;
				end else if (dozeEnable && idleNow) begin
					stateD = PWR_DOZE;
				end
			end
			PWR_RX: begin
				if (!rxActive) begin
					stateD = PWR_STANDBY;
				end
			end
			PWR_TX: begin
				if (!txRequest) begin
					stateD = PWR_STANDBY;
				end
			end
			PWR_DOZE: begin
				if (txRequest || !dozeEnable || pending_q) begin
					stateD = PWR_WAKE;
				end else if (dtimTick) begin
					stateD = PWR_DTIM;
				end
			end
			PWR_DTIM: begin
				stateD = trafficQueued ? PWR_RX : PWR_DOZE;
			end
			PWR_WAKE: begin
				if (timer_q == '0) begin
					stateD = PWR_STANDBY;
				end
			end
			default: begin
				stateD = PWR_HELD;
			end
		endcase
		if (holdReset) begin
			stateD = PWR_HELD;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= PWR_HELD;
		end else if (clkEn) begin
			state_q <= stateD;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			timer_q <= '0;
		end else if (clkEn) begin
			if (stateD == PWR_START && state_q != PWR_START) begin
				timer_q <= TW'(STARTUP_CYCLES - 1);
			end else if (stateD == PWR_WAKE && state_q != PWR_WAKE) begin
				timer_q <= TW'(WAKE_CYCLES - 1);
			end else if (timer_q != '0) begin
				timer_q <= timer_q - 1'b1;
			end
		end
	end

	// Status outputs; start-up flag drops on any hold
	logic regOn_q;
	logic coreRstN_q;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			regOn_q       <= 1'b0;
			coreRstN_q    <= 1'b0;
			startupDone_q <= 1'b0;
		end else if (clkEn) begin
			regOn_q    <= !hibS;
			coreRstN_q <= !holdReset;
			if (holdReset) begin
				startupDone_q <= 1'b0;
			end else if (state_q == PWR_START && stateD == PWR_STANDBY) begin
				startupDone_q <= 1'b1;
			end
		end
	end

	// Trace each state change so power tracing can follow stand-by
	logic       traceReq_q;
	logic [7:0] traceByte_q;
	logic       traceRdy;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			traceReq_q  <= 1'b0;
			traceByte_q <= TRACE_CODE_BASE;
		end else if (clkEn) begin
			if (stateD != state_q) begin
				traceReq_q  <= 1'b1;
				traceByte_q <= TRACE_CODE_BASE + {5'h00, stateD};
			end else if (traceRdy) begin
				traceReq_q <= 1'b0;
			end
		end
	end

	wmhs_trace_tx #(
		.BIT_CYC   (TRACE_CYCLES),
		.DATA_BITS (TRACE_DATA_BITS),
		.STOP_BITS (TRACE_STOP_BITS)
	) u_trace (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.clkEn     (clkEn),
		.byteIn    (traceByte_q),
		.byteValid (traceReq_q),
		.byteReady (traceRdy),
		.serialOut (traceSerialOut)
	);

	assign intPinO       = 1'b0;
	assign intPinOe      = intOe_q;
	assign coreDataReady = dataRdy_q;
	assign hostByte      = hostByte_q;
	assign hostByteValid = hostValid_q;
	assign regulatorsOn  = regOn_q;
	assign coreResetN    = coreRstN_q;
	assign startupDone   = startupDone_q;
	assign powerState    = state_q;

	// Helper count of cycles spent in the current state, cleared on every state change
	int unsigned dwell_q;
	always_ff @(posedge sys_clk) begin
		if (rst || stateD != state_q) begin
			dwell_q <= 0;
		end else if (clkEn) begin
			dwell_q <= dwell_q + 1;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst || !clkEn);

	hib_regs_off_a: assert property (hibS |=> !regulatorsOn)
		else $error("regulators on during power-down");
	por_hold_a: assert property (!supS |=> powerState == PWR_HELD
		&& !coreResetN) else $error("bad supply not held in reset");
	startup_len_a: assert property ((state_q == PWR_START
		&& stateD == PWR_STANDBY) |-> dwell_q == STARTUP_CYCLES - 1)
		else $error("start-up period wrong length");
	hib_wipe_a: assert property (hibS |=> !pending_q && !startupDone)
		else $error("state kept through power-down");
	doze_entry_a: assert property ((state_q == PWR_STANDBY && !holdReset
		&& dozeEnable && idleNow) |=> powerState == PWR_DOZE)
		else $error("idle module did not doze");
	dtim_check_a: assert property ((state_q == PWR_DOZE && dtimTick
		&& !holdReset && dozeEnable && !txRequest && !pending_q)
		|=> powerState == PWR_DTIM ##1 (powerState == PWR_HELD
		|| powerState == PWR_RX || powerState == PWR_DOZE))
		else $error("beacon check sequence broken");
	wake_len_a: assert property ((state_q == PWR_WAKE
		&& stateD == PWR_STANDBY) |-> dwell_q == WAKE_CYCLES - 1)
		else $error("doze exit wrong length");
	standby_src_a: assert property ((stateD == PWR_STANDBY
		&& state_q != PWR_STANDBY) |-> state_q inside {PWR_START,
		PWR_RX, PWR_TX, PWR_WAKE}) else $error("bad stand-by entry");
	int_assert_a: assert property ($rose(pending_q) && !hibS
		|=> intPinOe && !intPinO) else $error("interrupt not driven low");
	int_release_a: assert property ($fell(pending_q) && !hibS
		|-> $past(xferDone) ##1 !intPinOe)
		else $error("interrupt released without transfer");

	startup_c: cover property ($rose(startupDone));
	dtim_fetch_c: cover property (powerState == PWR_DTIM ##1
		powerState == PWR_RX);
	spi_byte_c: cover property (hostByteValid ##[1:200] xferDone);
	int_cycle_c: cover property ($rose(intPinOe) ##[1:1000] $fell(intPinOe));
endmodule // wmhs_top

// *** rtl/wmhs_trace_tx.sv ***
// Serial trace transmitter, one start bit, data LSB first, stop bits high
`timescale 1ns/1ps
module wmhs_trace_tx import wmhs_pkg::*; #(
	parameter int unsigned BIT_CYC   = TRACE_BIT_CYC,
	parameter int unsigned DATA_BITS = TRACE_DATA_BITS,
	parameter int unsigned STOP_BITS = TRACE_STOP_BITS
) (
	// Clock, reset, enable
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	input  wire logic                 clkEn,
	// Byte handover
	input  wire logic [DATA_BITS-1:0] byteIn,
	input  wire logic                 byteValid,
	output logic                      byteReady,
	// Serial line
	output logic                      serialOut
);
	localparam int unsigned FRAME_BITS = DATA_BITS + 1 + STOP_BITS;
	localparam int unsigned BCW        = $clog2(BIT_CYC);
	localparam int unsigned NCW        = $clog2(FRAME_BITS + 1);

	logic [BCW-1:0]        baudCnt_q;
	logic [NCW-1:0]        bitsLeft_q;
	logic [FRAME_BITS-1:0] frame_q;
	logic                  ready_q;

	// No flow control: the frame goes out whatever the far end does
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			baudCnt_q  <= '0;
			bitsLeft_q <= '0;
			frame_q    <= '1;
			ready_q    <= 1'b1;
		end else if (clkEn) begin
			if (bitsLeft_q == '0) begin
				if (byteValid && ready_q) begin
					frame_q    <= {{STOP_BITS{1'b1}}, byteIn, 1'b0};
					bitsLeft_q <= NCW'(FRAME_BITS);
					baudCnt_q  <= BCW'(BIT_CYC - 1);
					ready_q    <= 1'b0;
				end
			end else if (baudCnt_q == '0) begin
				frame_q    <= {1'b1, frame_q[FRAME_BITS-1:1]};
				bitsLeft_q <= bitsLeft_q - 1'b1;
				baudCnt_q  <= BCW'(BIT_CYC - 1);
				ready_q    <= (bitsLeft_q == NCW'(1));
			end else begin
				baudCnt_q <= baudCnt_q - 1'b1;
			end
		end
	end

	assign serialOut = frame_q[0];
	assign byteReady = ready_q;

	trace_start_a: assert property (@(posedge sys_clk) disable iff (rst)
		(byteValid && ready_q && clkEn) |=> !serialOut && !byteReady)
		else $error("trace start bit missing");
	trace_bit_a: assert property (@(posedge sys_clk) disable iff (rst)
		(bitsLeft_q != '0 && baudCnt_q != '0) |=> $stable(serialOut))
		else $error("trace bit shorter than one baud period");
endmodule // wmhs_trace_tx

// *** tb/wmhs_host_model.sv ***
// Host microcontroller model acting as SPI master
`timescale 1ns/1ps
module wmhs_host_model (
	// SPI master pins
	output logic      spiSck,
	output logic      spiCsN,
	output logic      spiSdi,
	input  wire logic spiSdo
);
	initial begin
		spiSck = 1'b0;
		spiCsN = 1'b1;
		spiSdi = 1'b0;
	end

	// One byte frame, 32 ns clock that stands still outside frames
	task automatic xfer(input logic mode3, input logic [7:0] tx,
		output logic [7:0] rx);
		spiSck = mode3;
		#16;
		spiCsN = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			spiSck = 1'b0;
			spiSdi = tx[i];
			#16;
			rx[i] = spiSdo;
			spiSck = 1'b1;
			#16;
		end
		#16;
		spiSck = mode3;
		#200;
		spiCsN = 1'b1;
		// Released line shows the inverse, not the last bit
		spiSdi = ~spiSdi;
		#200;
	endtask
endmodule // wmhs_host_model

// *** tb/wmhs_top_tb.sv ***
// Self-checking bench for the host link and power block
`timescale 1ns/1ps
module wmhs_top_tb;
	import wmhs_pkg::*;
	localparam int TBIT = 4;
	logic       sys_clk, rst, hibernatePin, resetPinN, supplyOk;
	logic       spiSck, spiCsN, spiSdi, spiSdo, intPinO, intPinOe;
	logic       traceSerialOut, coreDataValid, coreDataReady;
	logic       hostByteValid, dozeEnable, activityBusy, dtimTick;
	logic       trafficQueued, rxActive, txRequest, regulatorsOn;
	logic       coreResetN, startupDone;
	logic [7:0] coreDataByte, hostByte, lastTrace, rx;
	logic [2:0] powerState;
	int         err_total, comparisons, cycles, byteCount;
	wire        intPin = intPinOe ? intPinO : 1'b1; // Pull-up

	wmhs_top #(.STARTUP_CYCLES(50), .WAKE_CYCLES(20),
		.TRACE_CYCLES(TBIT)) uut (
		.sys_clk(sys_clk), .rst(rst), .clkEn(1'b1),
		.hibernatePin(hibernatePin), .resetPinN(resetPinN),
		.supplyOk(supplyOk), .spiSck(spiSck), .spiCsN(spiCsN),
		.spiSdi(spiSdi), .spiSdo(spiSdo), .intPinO(intPinO),
		.intPinOe(intPinOe), .traceSerialOut(traceSerialOut),
		.coreDataByte(coreDataByte), .coreDataValid(coreDataValid),
		.coreDataReady(coreDataReady), .hostByte(hostByte),
		.hostByteValid(hostByteValid), .dozeEnable(dozeEnable),
		.activityBusy(activityBusy), .dtimTick(dtimTick),
		.trafficQueued(trafficQueued), .rxActive(rxActive),
		.txRequest(txRequest), .regulatorsOn(regulatorsOn),
		.coreResetN(coreResetN), .startupDone(startupDone),
		.powerState(powerState));

	wmhs_host_model host (.spiSck(spiSck), .spiCsN(spiCsN),
		.spiSdi(spiSdi), .spiSdo(spiSdo));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// Trace decoder, samples mid-bit, LSB first
	initial begin
		lastTrace = 8'h00;
		forever begin
			@(negedge traceSerialOut);
			repeat (TBIT + TBIT / 2) @(posedge sys_clk);
			for (int i = 0; i < 8; i++) begin
				lastTrace[i] = traceSerialOut;
				repeat (TBIT) @(posedge sys_clk);
			end
		end
	end

	task automatic stop_test();
		$display("Counts: %0d compared, %0d failed", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			stop_test();
		end
	end

	// Count received-byte pulses away from the launching edge
	always @(negedge sys_clk) begin
		if (hostByteValid === 1'b1)
			byteCount++;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic ld(input logic [7:0] b);
		for (int i = 0; i < 100 && coreDataReady !== 1'b1; i++)
			cyc(1);
		coreDataByte = b;
		coreDataValid = 1'b1;
		cyc(1);
		coreDataValid = 1'b0;
		cyc(2);
	endtask

	task automatic t_start();
		rst = 1'b0;
		cyc(45);
		chk(powerState, PWR_START);
		cyc(10);
		chk(powerState, PWR_STANDBY);
		chk(startupDone, 1'b1);
		cyc(60);
		chk(lastTrace, TRACE_CODE_BASE + PWR_STANDBY);
		$display("test start done");
	endtask

	task automatic t_int(input logic m3, input logic [7:0] d,
		input logic [7:0] h);
		int n0;
		n0 = byteCount;
		ld(d);
		chk(intPinOe, 1'b1);
		chk(intPin, 1'b0);
		host.xfer(m3, h, rx);
		chk(rx, d);
		chk(hostByte, h);
		chk(byteCount - n0, 1);
		cyc(2);
		chk(intPin, 1'b1);
		$display("test interrupt mode %0d done", m3 ? 3 : 0);
	endtask

	task automatic t_doze();
		activityBusy = 1'b1;
		dozeEnable = 1'b1;
		cyc(5);
		chk(powerState, PWR_STANDBY);
		activityBusy = 1'b0;
		cyc(3);
		chk(powerState, PWR_DOZE);
		trafficQueued = 1'b1;
		rxActive = 1'b1;
		dtimTick = 1'b1;
		cyc(1);
		dtimTick = 1'b0;
		chk(powerState, PWR_DTIM);
		cyc(1);
		chk(powerState, PWR_RX);
		rxActive = 1'b0;
		trafficQueued = 1'b0;
		cyc(4);
		dtimTick = 1'b1;
		cyc(1);
		dtimTick = 1'b0;
		chk(powerState, PWR_DTIM);
		cyc(1);
		chk(powerState, PWR_DOZE);
		txRequest = 1'b1;
		cyc(1);
		chk(powerState, PWR_WAKE);
		cyc(17);
		chk(powerState, PWR_WAKE);
		cyc(5);
		chk(powerState !== PWR_WAKE, 1'b1);
		txRequest = 1'b0;
		dozeEnable = 1'b0;
		cyc(4);
		chk(powerState, PWR_STANDBY);
		$display("test doze done");
	endtask

	task automatic t_hib();
		ld(8'h5a);
		hibernatePin = 1'b1;
		resetPinN = 1'b0;
		cyc(5);
		chk(regulatorsOn, 1'b0);
		chk(powerState, PWR_HELD);
		chk({startupDone, intPinOe}, 2'b00);
		chk(coreResetN, 1'b0);
		hibernatePin = 1'b0;
		cyc(5);
		chk(regulatorsOn, 1'b1);
		// Scaled stand-in for the host's wait before reset release
		cyc(20);
		chk(powerState, PWR_HELD);
		resetPinN = 1'b1;
		cyc(5);
		chk(powerState, PWR_START);
		cyc(55);
		chk(powerState, PWR_STANDBY);
		supplyOk = 1'b0;
		cyc(4);
		chk(powerState, PWR_HELD);
		supplyOk = 1'b1;
		cyc(60);
		chk(startupDone, 1'b1);
		$display("test power pins done");
	endtask

	initial begin
		err_total = 0;
		comparisons = 0;
		byteCount = 0;
		rst = 1'b1;
		hibernatePin = 1'b0;
		resetPinN = 1'b1;
		supplyOk = 1'b1;
		coreDataByte = 8'h00;
		coreDataValid = 1'b0;
		dozeEnable = 1'b0;
		activityBusy = 1'b0;
		dtimTick = 1'b0;
		trafficQueued = 1'b0;
		rxActive = 1'b0;
		txRequest = 1'b0;
		cyc(20);
		t_start();
		t_int(1'b0, 8'ha5, 8'h3c);
		t_int(1'b1, 8'h96, 8'hc3);
		t_doze();
		t_hib();
		t_int(1'b1, 8'h81, 8'h7e);
		stop_test();
	end
endmodule // wmhs_top_tb
